// ---- hw/fke_consts.svh ----
// function keypad entry: constants for key settling, byte codes and commands
// assumes a 100 MHz core clock; included by the design and the checker
`ifndef FKE_CONSTS_SVH
`define FKE_CONSTS_SVH
`define FKE_CLK_MHZ        100
`define FKE_SETTLE_MS      36
`define FKE_SETTLE_CYC     (`FKE_SETTLE_MS * 1000 * `FKE_CLK_MHZ)
`define FKE_SRC_BIT        1
`define FKE_SRC_BYTE       8'h40
`define FKE_CMD_READ_INPUTS 8'h06
`define FKE_CNT_FIRST      2'h0
`define FKE_CNT_SECOND     2'h1
`define FKE_CNT_THIRD      2'h2
`endif

// ---- hw/fke_pkg.sv ----
// function keypad entry: shared types
// assumes fke_consts.svh for the numeric values
package fke_pkg;
  typedef enum logic [2:0] {
    IDLE, SELECT, SERVE, WAIT_ACK, ENDING
  } fke_state_type;

  typedef struct packed {
    logic       valid;   // one-cycle command strobe from the channel side
    logic [7:0] code;
  } fke_cmd_type;

  typedef struct packed {
    logic       serviceIn;
    logic [7:0] busIn;
  } fke_xfer_type;

  typedef struct packed {
    logic       attention;
    logic       unitCheck;
    logic       channelEnd;
    logic       cmdReject;
  } fke_status_type;
endpackage

// ---- hw/fke_keypad_entry.sv ----
// function keypad entry: key encoder, settle timer, key latch and the
// three-byte read sequence toward the host channel
// assumes channel handshake inputs are synchronous to core_clk
// assumes the channel answers every service in within bounded time
//
// Behaviour
// - key number encodes as straight five-bit binary
// - key press raises attention toward host
// - attention reported inside next status byte
// - light pen detection raises unit check
// - selection validates command, clears load counter
// - first service cycle starts after selection
// - cycle one sends source byte, count one
// - cycle two sends key code, count two
// - cycle three sends overlay byte
// - third transfer releases latch, starts ending
// - latch code after 36 ms, lockout held
// - source byte carries one in bit 6
// - overlay byte from eight sense switches
`include "fke_consts.svh"

// timing in brief: a key must stand SETTLE_CYC cycles before it latches;
// a read then runs select, then three serve and wait pairs, then ending;
// each byte stands as long as the channel takes to answer service in
module fke_keypad_entry #(
  parameter int unsigned SETTLE_CYC = `FKE_SETTLE_CYC,
  parameter int unsigned KEYS       = 32
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic [KEYS-1:0]       keyDown,
  input  wire logic [7:0]            overlaySense,
  input  wire logic                  penDetect,
  input  wire fke_pkg::fke_cmd_type  cmdIn,
  input  wire logic                  statusTake,
  input  wire logic                  serviceOut,
  output fke_pkg::fke_xfer_type      xferOut,
  output fke_pkg::fke_status_type    statusOut,
  output logic [4:0]                 keyCodeOut,
  output logic                       keyHeld
);
  // counter wide enough to hold the last settle count
  localparam int CW = $clog2(SETTLE_CYC + 1);

  // priority encoder; lowest pressed key wins when several are down
  // several keys at once is an operator slip; the code stays legal
  function automatic logic [5:0] encodeKey(input logic [KEYS-1:0] k);
    logic [5:0] r;
    r = 6'h00;
    // scan from the top so the lowest set index is written last
    for (int i = KEYS - 1; i >= 0; i--) begin
      if (k[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // key path state
  logic [5:0]            enc;
  logic [CW-1:0]         settle_q, settle_d;
  logic [4:0]            code_q, code_d;
  logic                  avail_q, avail_d;
  logic                  attn_q, attn_d;
  logic                  check_q, check_d;

  // channel path state
  logic                  chEnd_q, chEnd_d;
  logic                  rej_q, rej_d;
  logic [1:0]            cnt_q, cnt_d;
  fke_pkg::fke_state_type state_q, state_d;
  fke_pkg::fke_xfer_type  xfer_q, xfer_d;
  // latch release strobe from the channel path
  logic                  release_c;

  // bit 5 flags that some key is down
  assign enc = encodeKey(keyDown);

  // key path: settle timer, latch and attention raising
  always_comb begin
    settle_d = settle_q;
    code_d   = code_q;
    avail_d  = avail_q;
    attn_d   = attn_q;
    check_d  = check_q;
    // third byte gone: free the latch for the next press
    if (release_c) begin
      avail_d = 1'b0;
    end
    // a held code locks out new presses until the host reads it
    if (!avail_q && enc[5]) begin
      if (settle_q >= CW'(SETTLE_CYC - 1)) begin
        code_d   = enc[4:0];
        avail_d  = 1'b1;
        attn_d   = 1'b1;
        settle_d = '0;
      end else begin
        settle_d = settle_q + CW'(1);
      end
    end else if (!enc[5]) begin
      settle_d = '0; // bounce restarts the settle window
    end
    // attention and check leave with the status byte; new event wins
    if (statusTake) begin
      attn_d  = avail_d && !avail_q;
      check_d = 1'b0;
    end
    // pen hits go out by sense, never by the read command
    if (penDetect) begin
      check_d = 1'b1;
    end
  end

  // key path registers; reset empties the latch so no stale code leaves
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settle_q <= '0;
      code_q   <= 5'h00;
      avail_q  <= 1'b0;
      attn_q   <= 1'b0;
      check_q  <= 1'b0;
    end else begin
      settle_q <= settle_d;
      code_q   <= code_d;
      avail_q  <= avail_d;
      attn_q   <= attn_d;
      check_q  <= check_d;
    end
  end

  // channel sequence: selection, three service cycles, ending
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    xfer_d    = xfer_q;
    chEnd_d   = chEnd_q;
    rej_d     = rej_q;
    release_c = 1'b0;
    // a taken status byte clears the ending flags; a new set still wins
    if (statusTake) begin
      chEnd_d = 1'b0;
      rej_d   = 1'b0;
    end
    unique case (state_q)
      fke_pkg::IDLE: begin
        // commands are taken only while idle; a busy read ignores them
        if (cmdIn.valid) begin
          state_d = fke_pkg::SELECT;
        end
      end
      fke_pkg::SELECT: begin
        // only the read command is accepted here
        if (cmdIn.code == `FKE_CMD_READ_INPUTS) begin
          // load counter starts from zero for every accepted read
          cnt_d   = `FKE_CNT_FIRST;
          state_d = fke_pkg::SERVE;
        end else begin
          // anything else is refused and reported in the next status
          rej_d   = 1'b1;
          state_d = fke_pkg::IDLE;
        end
      end
      fke_pkg::SERVE: begin
        // byte and service in rise together and stand until answered
        xfer_d.serviceIn = 1'b1;
        // load counter picks the byte: source, key code, overlay
        unique case (cnt_q)
          `FKE_CNT_FIRST:  xfer_d.busIn = `FKE_SRC_BYTE;
          `FKE_CNT_SECOND: xfer_d.busIn = {3'h0, code_q};
          default:         xfer_d.busIn = overlaySense;
        endcase
        state_d = fke_pkg::WAIT_ACK;
      end
      fke_pkg::WAIT_ACK: begin
        // counter steps only once the channel has answered
        if (serviceOut) begin
          xfer_d.serviceIn = 1'b0;
          if (cnt_q == `FKE_CNT_THIRD) begin
            // last byte gone: free the latch and end the operation
            release_c = 1'b1;
            state_d   = fke_pkg::ENDING;
          end else begin
            cnt_d   = cnt_q + 2'h1;
            state_d = fke_pkg::SERVE;
          end
        end
      end
      fke_pkg::ENDING: begin
        // channel end stands until the status byte is taken
        chEnd_d = 1'b1;
        state_d = fke_pkg::IDLE;
      end
    endcase
  end

  // channel path registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= fke_pkg::IDLE;
      cnt_q   <= 2'h0;
      xfer_q  <= '0;
      chEnd_q <= 1'b0;
      rej_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      xfer_q  <= xfer_d;
      chEnd_q <= chEnd_d;
      rej_q   <= rej_d;
    end
  end

  // outputs straight from flops
  assign xferOut    = xfer_q;
  // status flags travel as one packed carrier
  assign statusOut  = '{attention: attn_q, unitCheck: check_q,
                        channelEnd: chEnd_q, cmdReject: rej_q};
  assign keyCodeOut = code_q;
  assign keyHeld    = avail_q;
endmodule // fke_keypad_entry

// ---- sim/fke_keypad_entry_asserts.sv ----
// checker on the keypad entry ports
// assumes one clock domain and async high reset
`include "fke_consts.svh"
module fke_keypad_entry_asserts (
  input wire logic                    core_clk,
  input wire logic                    rst,
  input wire logic                    penDetect,
  input wire fke_pkg::fke_cmd_type    cmdIn,
  input wire logic                    serviceOut,
  input wire fke_pkg::fke_xfer_type   xferOut,
  input wire fke_pkg::fke_status_type statusOut,
  input wire logic [4:0]              keyCodeOut,
  input wire logic                    keyHeld
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_HOLD: assert property (
    xferOut.serviceIn && !serviceOut |=> xferOut.serviceIn
    && $stable(xferOut.busIn)) else $error("byte not held");
  AST_DROP: assert property (
    xferOut.serviceIn && serviceOut |=> !xferOut.serviceIn)
    else $error("service in kept");
  AST_ATTN: assert property (
    $rose(keyHeld) |-> statusOut.attention) else $error("no attention");
  AST_LOCK: assert property (
    keyHeld && $past(keyHeld) |-> $stable(keyCodeOut))
    else $error("code moved");
  // valid seen, then select, then serve: service in is seen three later
  AST_SRC: assert property (
    $rose(xferOut.serviceIn) && $past(cmdIn.valid, 3)
    |-> xferOut.busIn == `FKE_SRC_BYTE) else $error("bad source byte");
  AST_REJ: assert property (
    $rose(statusOut.cmdReject) |-> $past(cmdIn.code)
    != `FKE_CMD_READ_INPUTS) else $error("good command refused");
  AST_END: assert property (
    $fell(keyHeld) |=> statusOut.channelEnd) else $error("no ending");
  AST_PEN: assert property (
    penDetect |=> statusOut.unitCheck) else $error("no unit check");
endmodule // fke_keypad_entry_asserts
bind fke_keypad_entry fke_keypad_entry_asserts i_fke_keypad_entry_asserts (
  .core_clk, .rst, .penDetect, .cmdIn, .serviceOut, .xferOut, .statusOut,
  .keyCodeOut, .keyHeld);

// ---- sim/fke_host_model.sv ----
// host channel model answering service in
// assumes it shares core_clk with the device
module fke_host_model (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic [3:0]            waitCyc,
  input wire fke_pkg::fke_xfer_type xferIn,
  output logic                      serviceOut
);
  logic [3:0] cnt_q;
  // one-cycle answer after waitCyc cycles; never answers an idle line
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q      <= 4'h0;
      serviceOut <= 1'b0;
    end else begin
      serviceOut <= xferIn.serviceIn && !serviceOut
                    && cnt_q == waitCyc;
      cnt_q      <= (xferIn.serviceIn && !serviceOut) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule // fke_host_model

// ---- sim/fke_keypad_entry_tb_top.sv ----
// keypad entry bench: key reads, refused command, pen check
// assumes settle shortened to 8 cycles
module fke_keypad_entry_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst = 1'b1, penDetect = 1'b0, statusTake = 1'b0;
  logic [31:0] keyDown = 32'h0;
  logic [7:0] overlaySense = 8'h00;
  logic [3:0] waitCyc = 4'h0;
  fke_pkg::fke_cmd_type cmdIn = 9'h000;
  fke_pkg::fke_xfer_type xferOut;
  fke_pkg::fke_status_type statusOut;
  logic [4:0] keyCodeOut;
  logic serviceOut, keyHeld;
  logic [7:0] got[$];
  int fail_count = 0, comparisons = 0, cycles = 0;
  always #5 core_clk = ~core_clk;
  fke_keypad_entry #(.SETTLE_CYC(8)) i_fke_keypad_entry (.core_clk, .rst,
    .keyDown, .overlaySense, .penDetect, .cmdIn, .statusTake, .serviceOut,
    .xferOut, .statusOut, .keyCodeOut, .keyHeld);
  fke_host_model i_fke_host_model (.core_clk, .rst, .waitCyc,
    .xferIn(xferOut), .serviceOut);
  // record each byte at its handshake edge; hang guard too
  always @(posedge core_clk) begin
    if (xferOut.serviceIn && serviceOut) got.push_back(xferOut.busIn);
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic take;
    statusTake = 1'b1;
    tick(1);
    statusTake = 1'b0;
  endtask
  // code stays put after valid drops, as selection samples it late
  task automatic cmd(input logic [7:0] c);
    cmdIn = {1'b1, c};
    tick(1);
    cmdIn.valid = 1'b0;
    tick(3);
  endtask
  task automatic key_read(input int k, input logic [3:0] w);
    got.delete();
    keyDown = 32'h1 << k;
    overlaySense = 8'ha5 ^ k[7:0];
    waitCyc = w;
    tick(12);
    chk({7'h0, statusOut.attention}, 8'h01);
    chk({3'h0, keyCodeOut}, k[7:0]);
    keyDown = 32'h1 << ((k + 1) % 32);
    tick(12);
    chk({3'h0, keyCodeOut}, k[7:0]);
    keyDown = 32'h0;
    take();
    chk({7'h0, statusOut.attention}, 8'h00);
    cmd(8'h06);
    for (int i = 0; i < 90 && statusOut.channelEnd !== 1'b1; i++) tick(1);
    chk({7'h0, statusOut.channelEnd}, 8'h01);
    chk(8'(got.size()), 8'h03);
    chk(got[0], 8'h40);
    chk(got[1], k[7:0]);
    chk(got[2], overlaySense);
    chk({7'h0, keyHeld}, 8'h00);
    take();
  endtask
  task automatic refuse_and_pen;
    cmd(8'h05);
    chk({7'h0, statusOut.cmdReject}, 8'h01);
    penDetect = 1'b1;
    tick(1);
    penDetect = 1'b0;
    tick(1);
    chk({7'h0, statusOut.unitCheck}, 8'h01);
  endtask
  task automatic final_report;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    tick(6);
    rst = 1'b0;
    tick(1);
    key_read(0, 4'h0);
    key_read(31, 4'h3);
    key_read(21, 4'h7);
    refuse_and_pen();
    final_report();
  end
endmodule // fke_keypad_entry_tb_top
